/* verilog/ccpc_ctrl.sv */
// Behaviour
// R1 - With output sync set, steering changes apply only at time base rollover or reset.
// R2 - Each set steering bit hands its compare output pin to this unit.
// R3 - Steering bits B to F exist only in the multi-output variant.
// R4 - Gate mode 10: falling gate edge sets capture inhibit.
// R5 - Gate mode 01: rising gate edge clears capture inhibit.
// R6 - Gate mode 00: gate level high enables, low disables capture; 11 reserved.
// R7 - Aux select: 11 events, 10 mode signal, 01 rollover, 00 off.
// R8 - Capture source: pin, comparator 1, comparator 2, cell 1, cell 2.
// R9 - With auto-restart, shutdown flag clears at next period once shutdown ended.
// R10 - Without auto-restart, software clears the shutdown flag before PWM resumes.
// R11 - Compare event flag sets on a single edge compare event.
// R12 - While capture inhibit is set, capture input events are ignored.
// R13 - Capture overflow flag sets when the capture FIFO overflows.
// R14 - Not-empty flag reads one while the capture buffer holds data.
// R15 - Event trigger positions read zero; writing one fires the event. The compare trigger shares STAT_CMP_BIT and reads back the compare flag.
// R16 - Unimplemented control two bits, including 30 and 21, read zero.
// R17 - Each permitted capture pushes the time base value; full push flags overflow.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module ccpc_ctrl #(
   parameter bit MULTI_OUTPUT = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire ccpc_pkg::ccpc_pins_s pins_in,
   input wire logic tb_rollover,
   input wire logic [ccpc_pkg::TB_W-1:0] tb_value,
   input wire logic cmp_event,
   input wire logic pwm_period_start,
   input wire logic mode_signal,
   input wire logic timer_mode,
   input wire logic compare_wave,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   output logic aux_out,
   output logic capture_event,
   output logic pwm_shutdown,
   output logic irq
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   ccpc_pkg::ccpc_pins_s pins_meta_reg;
   ccpc_pkg::ccpc_pins_s pins_sync_reg;
   ccpc_pkg::ccpc_pins_s pins_prev_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pins_meta_reg <= '0;
         pins_sync_reg <= '0;
         pins_prev_reg <= '0;
      end else begin
         pins_meta_reg <= pins_in;
         pins_sync_reg <= pins_meta_reg;
         pins_prev_reg <= pins_sync_reg;
      end
   end

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   logic [31:0] con2_reg;
   logic [5:0] steer_reg;
   logic inhibit_reg;
   logic cmp_flag_reg;
   logic ovf_flag_reg;
   logic shut_flag_reg;
   logic [ccpc_pkg::IRQ_W-1:0] irq_flags_reg;
   logic [ccpc_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [31:0] rdata_reg;

   wire wr_con2 = reg_wr && (reg_addr == ccpc_pkg::ADDR_CON2);
   wire wr_stat = reg_wr && (reg_addr == ccpc_pkg::ADDR_STAT);
   wire wr_flags = reg_wr && (reg_addr == ccpc_pkg::ADDR_IRQ_FLAGS);
   wire wr_mask = reg_wr && (reg_addr == ccpc_pkg::ADDR_IRQ_MASK);
   wire rd_data = reg_rd && (reg_addr == ccpc_pkg::ADDR_CAP_DATA_SEL);

   wire [31:0] con2_wmask = MULTI_OUTPUT ? ccpc_pkg::CON2_WMASK_MULTI
                                         : ccpc_pkg::CON2_WMASK_SINGLE; // R3
   wire [31:0] con2_next = (con2_reg & ~con2_wmask) | (reg_wdata & con2_wmask); // R16

   wire out_sync = con2_reg[ccpc_pkg::CON2_OUT_SYNC_BIT];
   wire [5:0] steer_req = con2_reg[ccpc_pkg::CON2_STEER_LSB +: 6];
   wire [1:0] gate_mode = con2_reg[ccpc_pkg::CON2_GATE_MODE_LSB +: 2];
   wire [1:0] aux_sel = con2_reg[ccpc_pkg::CON2_AUX_LSB +: 2];
   wire [2:0] src_sel = con2_reg[ccpc_pkg::CON2_SRC_LSB +: 3];
   wire auto_restart = con2_reg[ccpc_pkg::CON2_RESTART_BIT];

   // Write-one event trigger in status shares STAT_CMP_BIT, which reads back the stored compare flag
   wire sw_cmp_evt = wr_stat && reg_wdata[ccpc_pkg::STAT_CMP_BIT]; // R15
   wire sw_shut_clr = wr_stat && !reg_wdata[ccpc_pkg::STAT_SHUTDOWN_BIT];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         con2_reg <= ccpc_pkg::CON2_RESET;
      end else if (wr_con2) begin
         con2_reg <= con2_next;
      end
   end

   // ------------------------------------------------------------
   // Output steering
   // ------------------------------------------------------------
   wire steer_load = !out_sync || tb_rollover; // R1

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         steer_reg <= ccpc_pkg::CON2_RESET[ccpc_pkg::CON2_STEER_LSB +: 6];
      end else if (steer_load) begin
         steer_reg <= steer_req; // R1
      end
   end

   assign pin_oe = steer_reg; // R2
   assign pin_out = {6{compare_wave && !shut_flag_reg}} & steer_reg; // R2

   // ------------------------------------------------------------
   // Capture source and gating
   // ------------------------------------------------------------
   logic cap_src;
   always_comb begin
      if (src_sel == ccpc_pkg::SRC_PIN) begin
         cap_src = pins_sync_reg.capture_input_pin; // R8
      end else if (src_sel == ccpc_pkg::SRC_CMP1) begin
         cap_src = pins_sync_reg.cmp1;
      end else if (src_sel == ccpc_pkg::SRC_CMP2) begin
         cap_src = pins_sync_reg.cmp2;
      end else if (src_sel == ccpc_pkg::SRC_CELL1) begin
         cap_src = pins_sync_reg.cell1;
      end else if (src_sel == ccpc_pkg::SRC_CELL2) begin
         cap_src = pins_sync_reg.cell2;
      end else begin
         cap_src = 1'b0; // R8
      end
   end

   logic cap_src_prev;
   wire cap_prev_sel = (src_sel == ccpc_pkg::SRC_PIN) ? pins_prev_reg.capture_input_pin :
                       (src_sel == ccpc_pkg::SRC_CMP1) ? pins_prev_reg.cmp1 :
                       (src_sel == ccpc_pkg::SRC_CMP2) ? pins_prev_reg.cmp2 :
                       (src_sel == ccpc_pkg::SRC_CELL1) ? pins_prev_reg.cell1 :
                       (src_sel == ccpc_pkg::SRC_CELL2) ? pins_prev_reg.cell2 : 1'b0;
   assign cap_src_prev = cap_prev_sel;

   wire gate_rise = pins_sync_reg.gate && !pins_prev_reg.gate;
   wire gate_fall = !pins_sync_reg.gate && pins_prev_reg.gate;

   logic inhibit_next;
   always_comb begin
      inhibit_next = inhibit_reg;
      case (gate_mode)
         ccpc_pkg::CCPC_GATE_LEVEL: inhibit_next = !pins_sync_reg.gate; // R6
         ccpc_pkg::CCPC_GATE_RISE: begin
            if (gate_rise) begin
               inhibit_next = 1'b0; // R5
            end
         end
         ccpc_pkg::CCPC_GATE_FALL: begin
            if (gate_fall) begin
               inhibit_next = 1'b1; // R4
            end
         end
         default: inhibit_next = inhibit_reg; // R6
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         inhibit_reg <= 1'b0;
      end else begin
         inhibit_reg <= inhibit_next;
      end
   end

   wire cap_edge = cap_src && !cap_src_prev;
   assign capture_event = cap_edge && !inhibit_reg; // R12

   // ------------------------------------------------------------
   // Capture FIFO
   // ------------------------------------------------------------
   localparam int PTR_W = $clog2(ccpc_pkg::FIFO_DEPTH);
   logic [ccpc_pkg::TB_W-1:0] fifo_mem [ccpc_pkg::FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0] count_reg;

   wire fifo_full = (count_reg == (PTR_W+1)'(ccpc_pkg::FIFO_DEPTH));
   wire fifo_empty = (count_reg == '0);
   wire do_push = capture_event && !fifo_full; // R17
   wire push_ovf = capture_event && fifo_full; // R13
   wire do_pop = rd_data && !fifo_empty;

   always_ff @(posedge core_clk) begin
      if (do_push) begin
         fifo_mem[wr_ptr_reg] <= tb_value; // R17
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + PTR_W'(do_push);
         rd_ptr_reg <= rd_ptr_reg + PTR_W'(do_pop);
         count_reg <= count_reg + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
      end
   end

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   wire cmp_set = cmp_event || sw_cmp_evt; // R11
   wire shut_set = pins_sync_reg.shutdown;
   wire shut_auto_clr = auto_restart && pwm_period_start && !pins_sync_reg.shutdown; // R9
   wire stat_ovf_clr = wr_stat && !reg_wdata[ccpc_pkg::STAT_OVF_BIT];
   wire stat_cmp_clr = wr_stat && !reg_wdata[ccpc_pkg::STAT_CMP_BIT];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cmp_flag_reg <= 1'b0;
         ovf_flag_reg <= 1'b0;
         shut_flag_reg <= 1'b0;
      end else begin
         cmp_flag_reg <= cmp_set || (cmp_flag_reg && !stat_cmp_clr); // R11
         ovf_flag_reg <= push_ovf || (ovf_flag_reg && !stat_ovf_clr); // R13
         shut_flag_reg <= shut_set ||
                          (shut_flag_reg && !shut_auto_clr && !sw_shut_clr); // R9 R10
      end
   end

   assign pwm_shutdown = shut_flag_reg;

   // ------------------------------------------------------------
   // Auxiliary output
   // ------------------------------------------------------------
   logic aux_reg;
   logic aux_next;
   always_comb begin
      case (aux_sel)
         ccpc_pkg::CCPC_AUX_EVT: aux_next = !timer_mode && (capture_event || cmp_event); // R7
         ccpc_pkg::CCPC_AUX_MODE: aux_next = mode_signal; // R7
         ccpc_pkg::CCPC_AUX_ROLL: aux_next = tb_rollover; // R7
         default: aux_next = 1'b0; // R7
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aux_reg <= 1'b0;
      end else begin
         aux_reg <= aux_next;
      end
   end

   assign aux_out = aux_reg;

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   wire [ccpc_pkg::IRQ_W-1:0] irq_events = {shut_set && !shut_flag_reg, push_ovf,
                                            capture_event, cmp_set};

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_flags_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         irq_flags_reg <= irq_events |
                          (irq_flags_reg & ~({ccpc_pkg::IRQ_W{wr_flags}} &
                                             reg_wdata[ccpc_pkg::IRQ_W-1:0]));
         if (wr_mask) begin
            irq_mask_reg <= reg_wdata[ccpc_pkg::IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_flags_reg & irq_mask_reg);

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   logic [31:0] con2_view;
   logic [31:0] stat_view;
   logic [31:0] rd_mux;

   always_comb begin
      con2_view = con2_reg & con2_wmask; // R16
      con2_view[ccpc_pkg::CON2_STEER_LSB +: 6] =
         steer_req & con2_wmask[ccpc_pkg::CON2_STEER_LSB +: 6]; // R3
      stat_view = '0; // R15
      stat_view[ccpc_pkg::STAT_SHUTDOWN_BIT] = shut_flag_reg;
      stat_view[ccpc_pkg::STAT_CMP_BIT] = cmp_flag_reg;
      stat_view[ccpc_pkg::STAT_INHIBIT_BIT] = inhibit_reg;
      stat_view[ccpc_pkg::STAT_OVF_BIT] = ovf_flag_reg;
      stat_view[ccpc_pkg::STAT_NE_BIT] = !fifo_empty; // R14
      if (reg_addr == ccpc_pkg::ADDR_CON2) begin
         rd_mux = con2_view;
      end else if (reg_addr == ccpc_pkg::ADDR_STAT) begin
         rd_mux = stat_view;
      end else if (reg_addr == ccpc_pkg::ADDR_IRQ_FLAGS) begin
         rd_mux = {{(32 - ccpc_pkg::IRQ_W){1'b0}}, irq_flags_reg};
      end else if (reg_addr == ccpc_pkg::ADDR_IRQ_MASK) begin
         rd_mux = {{(32 - ccpc_pkg::IRQ_W){1'b0}}, irq_mask_reg};
      end else if (reg_addr == ccpc_pkg::ADDR_CAP_DATA_SEL) begin
         rd_mux = fifo_empty ? '0
                 : {{(32 - ccpc_pkg::TB_W){1'b0}}, fifo_mem[rd_ptr_reg]};
      end else begin
         rd_mux = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         rdata_reg <= rd_mux;
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata = rdata_reg;

endmodule : ccpc_ctrl

/* shared/ccpc_pkg.sv */
package ccpc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CON2 = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
   localparam logic [3:0] ADDR_CAP_DATA = 4'h0;
   localparam logic [3:0] ADDR_CAP_DATA_SEL = 4'h1;

   // ------------------------------------------------------------
   // Control two field layout
   // ------------------------------------------------------------
   localparam int CON2_OUT_SYNC_BIT = 31;
   localparam int CON2_STEER_LSB = 24;
   localparam int CON2_GATE_MODE_LSB = 22;
   localparam int CON2_AUX_LSB = 19;
   localparam int CON2_SRC_LSB = 16;
   localparam int CON2_RESTART_BIT = 15;
   localparam logic [31:0] CON2_WMASK_MULTI = 32'hbfdf_8000;
   localparam logic [31:0] CON2_WMASK_SINGLE = 32'h81df_8000;
   localparam logic [31:0] CON2_RESET = 32'h0100_0000;

   // ------------------------------------------------------------
   // Status field layout
   // ------------------------------------------------------------
   localparam int STAT_SHUTDOWN_BIT = 4;
   localparam int STAT_CMP_BIT = 3;
   localparam int STAT_INHIBIT_BIT = 2;
   localparam int STAT_OVF_BIT = 1;
   localparam int STAT_NE_BIT = 0;

   // Interrupt status bits
   localparam int IRQ_CMP = 0;
   localparam int IRQ_CAP = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_SHUT = 3;
   localparam int IRQ_W = 4;

   localparam int FIFO_DEPTH = 4;
   localparam int TB_W = 16;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CCPC_GATE_LEVEL = 2'h0,
      CCPC_GATE_RISE = 2'h1,
      CCPC_GATE_FALL = 2'h2,
      CCPC_GATE_RSVD = 2'h3
   } ccpc_gate_e;

   typedef enum logic [1:0] {
      CCPC_AUX_OFF = 2'h0,
      CCPC_AUX_ROLL = 2'h1,
      CCPC_AUX_MODE = 2'h2,
      CCPC_AUX_EVT = 2'h3
   } ccpc_aux_e;

   localparam logic [2:0] SRC_PIN = 3'h0;
   localparam logic [2:0] SRC_CMP1 = 3'h1;
   localparam logic [2:0] SRC_CMP2 = 3'h2;
   localparam logic [2:0] SRC_CELL1 = 3'h4;
   localparam logic [2:0] SRC_CELL2 = 3'h5;

   // Raw signals from the outside world
   typedef struct packed {
      logic capture_input_pin;
      logic cmp1;
      logic cmp2;
      logic cell1;
      logic cell2;
      logic gate;
      logic shutdown;
   } ccpc_pins_s;

endpackage : ccpc_pkg

/* sim/ccpc_ctrl_properties.sv */
`timescale 1ns/1ns
module ccpc_ctrl_chk (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire ccpc_pkg::ccpc_pins_s pins_in,
   input wire logic tb_rollover,
   input wire logic pwm_period_start,
   input wire logic mode_signal,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic aux_out,
   input wire logic capture_event,
   input wire logic pwm_shutdown
);
   logic up_q;
   logic [15:0] ctl_q;
   logic [2:0] low_cnt;
   wire sw_clr = reg_wr && reg_addr == ccpc_pkg::ADDR_STAT && !reg_wdata[4];
   wire [1:0] aux_sel = ctl_q[4:3];
   wire [1:0] gate_sel = ctl_q[7:6];
   // Shadow of control two upper half, gate low time
   always_ff @(posedge core_clk) begin
      up_q <= rst_n;
      if (!rst_n)
         ctl_q <= 16'h0;
      else if (reg_wr && reg_addr == ccpc_pkg::ADDR_CON2)
         ctl_q <= reg_wdata[31:16];
      if (!rst_n || pins_in.gate)
         low_cnt <= 3'h0;
      else if (low_cnt != 3'h7)
         low_cnt <= low_cnt + 3'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence shut_held;
      pins_in.shutdown [*3];
   endsequence
   sequence sync_steady;
      (up_q && ctl_q[15]) [*2] ##1 (up_q && $changed(pin_oe));
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   pin_own_a: assert property ((pin_out & ~pin_oe) == 6'h0)
      else $error("pin driven while not steered");
   shut_quiet_a: assert property (pwm_shutdown |-> pin_out == 6'h0)
      else $error("pin active during shutdown");
   sync_hold_a: assert property (sync_steady |-> $past(tb_rollover))
      else $error("steering changed off rollover");
   aux_off_a: assert property (aux_sel == ccpc_pkg::CCPC_AUX_OFF |=> !aux_out)
      else $error("aux active while off");
   aux_roll_a: assert property (aux_sel == ccpc_pkg::CCPC_AUX_ROLL |=> aux_out == $past(tb_rollover))
      else $error("aux not following rollover");
   aux_mode_a: assert property (aux_sel == ccpc_pkg::CCPC_AUX_MODE |=> aux_out == $past(mode_signal))
      else $error("aux not following mode signal");
   gate_level_a: assert property (gate_sel == 2'h0 && $past(gate_sel) == 2'h0 && low_cnt == 3'h7 |-> !capture_event)
      else $error("capture while gate low");
   shut_set_a: assert property (shut_held |=> ##[0:2] pwm_shutdown)
      else $error("shutdown flag not set");
   shut_clr_a: assert property (up_q && $fell(pwm_shutdown) |-> $past(pwm_period_start) || $past(sw_clr))
      else $error("shutdown flag cleared without cause");
endmodule : ccpc_ctrl_chk
bind ccpc_ctrl ccpc_ctrl_chk ccpc_ctrl_chk_i (.core_clk(core_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pins_in(pins_in), .tb_rollover(tb_rollover),
   .pwm_period_start(pwm_period_start), .mode_signal(mode_signal), .pin_out(pin_out),
   .pin_oe(pin_oe), .aux_out(aux_out), .capture_event(capture_event),
   .pwm_shutdown(pwm_shutdown));

/* sim/ccpc_far_model.sv */
`timescale 1ns/1ns
module ccpc_far_model (
   input wire logic core_clk,
   input wire logic [2:0] src_sel,
   input wire logic fire,
   input wire logic gate,
   input wire logic shutdown,
   output ccpc_pkg::ccpc_pins_s pins
);
   logic [2:0] hold_cnt = 3'h0;
   wire hi = hold_cnt != 3'h0;
   // Long enough high to pass the input synchroniser
   always_ff @(posedge core_clk) begin
      if (fire)
         hold_cnt <= 3'h4;
      else if (hi)
         hold_cnt <= hold_cnt - 3'h1;
   end
   always_comb begin
      pins.capture_input_pin = hi && src_sel == ccpc_pkg::SRC_PIN;
      pins.cmp1 = hi && src_sel == ccpc_pkg::SRC_CMP1;
      pins.cmp2 = hi && src_sel == ccpc_pkg::SRC_CMP2;
      pins.cell1 = hi && src_sel == ccpc_pkg::SRC_CELL1;
      pins.cell2 = hi && src_sel == ccpc_pkg::SRC_CELL2;
      pins.gate = gate;
      pins.shutdown = shutdown;
   end
endmodule : ccpc_far_model

/* sim/tb_capture_compare_pwm_ctrl.sv */
`timescale 1ns/1ns
module tb_capture_compare_pwm_ctrl;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [3:0] pl = 4'h0;
   logic [15:0] tbv = 16'h0;
   logic mode_sig = 1'b0;
   logic wave = 1'b0;
   logic gate = 1'b1;
   logic shut = 1'b0;
   logic [2:0] src = 3'h0;
   logic [31:0] rdata;
   logic [5:0] pin_out, pin_oe;
   logic aux, cap_ev, shut_flag, irq;
   ccpc_pkg::ccpc_pins_s pins;
   logic [31:0] rng = 32'h4f;
   logic [15:0] exp_q[$];
   logic [2:0] srcs [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
   int cap_cnt = 0;
   int err_total = 0;
   int n_compared = 0;
   always #10 core_clk = ~core_clk;
   ccpc_ctrl #(.MULTI_OUTPUT(1'b1)) ccpc_ctrl_i (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
      .pins_in(pins), .tb_rollover(pl[0]), .tb_value(tbv), .cmp_event(pl[1]),
      .pwm_period_start(pl[2]), .mode_signal(mode_sig), .timer_mode(1'b0),
      .compare_wave(wave), .pin_out(pin_out), .pin_oe(pin_oe), .aux_out(aux),
      .capture_event(cap_ev), .pwm_shutdown(shut_flag), .irq(irq));
   ccpc_far_model ccpc_far_model_i (.core_clk(core_clk), .src_sel(src), .fire(pl[3]),
      .gate(gate), .shutdown(shut), .pins(pins));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   always @(posedge core_clk) begin
      rng <= xs(rng);
      tbv <= rng[15:0];
      wave <= rng[16];
      mode_sig <= rng[17];
   end
   always @(posedge core_clk)
      if (rst_n && cap_ev) begin
         cap_cnt <= cap_cnt + 1;
         if (exp_q.size() < ccpc_pkg::FIFO_DEPTH)
            exp_q.push_back(tbv);
      end
   task automatic end_sim;
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge core_clk);
      wr_s <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge core_clk);
      rd_s <= 1'b0;
      @(posedge core_clk);
      chk(rdata & m, e);
   endtask : rd
   task automatic pulse(input logic [3:0] m);
      pl <= m;
      @(posedge core_clk);
      pl <= 4'h0;
      @(posedge core_clk);
   endtask : pulse
   task automatic cap(input int n);
      int c0;
      c0 = cap_cnt;
      pulse(4'h8);
      repeat (8) @(posedge core_clk);
      chk(32'(cap_cnt - c0), 32'(n));
   endtask : cap
   task automatic gs(input logic [1:0] m, input logic g, input logic inh, input int n);
      wr(ccpc_pkg::ADDR_CON2, {8'h01, m, 22'h0});
      gate <= g;
      repeat (6) @(posedge core_clk);
      rd(ccpc_pkg::ADDR_STAT, 32'h4, {29'h0, inh, 2'h0});
      cap(n);
   endtask : gs
   task automatic shut_run(input logic rs);
      wr(ccpc_pkg::ADDR_CON2, {16'h0100, rs, 15'h0});
      shut <= 1'b1;
      repeat (5) @(posedge core_clk);
      pulse(4'h4);
      chk({31'h0, shut_flag}, 32'h1);
      shut <= 1'b0;
      repeat (4) @(posedge core_clk);
      pulse(4'h4);
      chk({31'h0, shut_flag}, {31'h0, !rs});
   endtask : shut_run
   initial begin
      #200000;
      err_total++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(ccpc_pkg::ADDR_CON2, 32'hffff_ffff, 32'h0100_0000);
      rd(ccpc_pkg::ADDR_STAT, 32'hffff_ffff, 32'h0);
      rd(4'h2, 32'hffff_ffff, 32'h0);
      wr(ccpc_pkg::ADDR_CON2, 32'hffff_ffff);
      rd(ccpc_pkg::ADDR_CON2, 32'hffff_ffff, 32'hbfdf_8000);
      chk({26'h0, pin_oe}, 32'h1);
      pulse(4'h1);
      chk({26'h0, pin_oe}, 32'h3f);
      chk({26'h0, pin_out}, {26'h0, {6{wave}}});
      wr(ccpc_pkg::ADDR_CON2, 32'h0);
      @(posedge core_clk);
      chk({26'h0, pin_oe}, 32'h0);
      chk({26'h0, pin_out}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(ccpc_pkg::ADDR_CON2, {11'h0, i[1:0], 19'h0});
         pulse(4'h3);
         if (i != 2)
            chk({31'h0, aux}, {31'h0, i[0]});
      end
      for (int k = 0; k < 6; k++) begin
         src <= (k == 5) ? 3'h0 : srcs[k];
         wr(ccpc_pkg::ADDR_CON2, {13'h0, srcs[k], 16'h0});
         cap(k < 5);
      end
      rd(ccpc_pkg::ADDR_STAT, 32'h3, 32'h3);
      rd(ccpc_pkg::ADDR_IRQ_FLAGS, 32'h6, 32'h6);
      repeat (4) rd(ccpc_pkg::ADDR_CAP_DATA_SEL, 32'hffff, {16'h0, exp_q.pop_front()});
      rd(ccpc_pkg::ADDR_STAT, 32'h1, 32'h0);
      rd(ccpc_pkg::ADDR_CAP_DATA_SEL, 32'hffff_ffff, 32'h0);
      wr(ccpc_pkg::ADDR_STAT, 32'h0);
      wr(ccpc_pkg::ADDR_IRQ_FLAGS, 32'hf);
      rd(ccpc_pkg::ADDR_STAT, 32'h2, 32'h0);
      rd(ccpc_pkg::ADDR_IRQ_FLAGS, 32'hf, 32'h0);
      gs(2'h0, 1'b0, 1'b1, 0);
      gs(2'h0, 1'b1, 1'b0, 1);
      gs(2'h2, 1'b0, 1'b1, 0);
      gs(2'h2, 1'b1, 1'b1, 0);
      gs(2'h1, 1'b0, 1'b1, 0);
      gs(2'h1, 1'b1, 1'b0, 1);
      wr(ccpc_pkg::ADDR_IRQ_FLAGS, 32'hf);
      wr(ccpc_pkg::ADDR_IRQ_MASK, 32'h1);
      pulse(4'h2);
      rd(ccpc_pkg::ADDR_STAT, 32'h8, 32'h8);
      chk({31'h0, irq}, 32'h1);
      wr(ccpc_pkg::ADDR_IRQ_MASK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(ccpc_pkg::ADDR_IRQ_FLAGS, 32'h1);
      wr(ccpc_pkg::ADDR_IRQ_MASK, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(ccpc_pkg::ADDR_STAT, 32'h0);
      rd(ccpc_pkg::ADDR_STAT, 32'h8, 32'h0);
      wr(ccpc_pkg::ADDR_STAT, 32'h8);
      rd(ccpc_pkg::ADDR_STAT, 32'h8, 32'h8);
      chk({31'h0, irq}, 32'h1);
      shut_run(1'b0);
      wr(ccpc_pkg::ADDR_STAT, 32'h0);
      chk({31'h0, shut_flag}, 32'h0);
      shut_run(1'b1);
      end_sim();
   end
endmodule : tb_capture_compare_pwm_ctrl
